/* inc/rlos_pkg.sv */
// Package of constants and types for the relay logical output seal-in block
`default_nettype none
package rlos_pkg;
  // Alarm condition count and widths
  localparam int unsigned ALARM_COUNT = 8;
  localparam int unsigned IDX_W       = 3;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 32;

  // Register word offsets (plain register port)
  localparam logic [3:0] REG_REALTIME  = 4'h0;
  localparam logic [3:0] REG_LATCHED   = 4'h1;
  localparam logic [3:0] REG_CLEAR     = 4'h2;
  localparam logic [3:0] REG_CONTROL   = 4'h3;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT  = 4'h5;
  localparam logic [3:0] REG_IRQ_CLR   = 4'h6;
  localparam logic [3:0] REG_IRQ_EN    = 4'h7;
  localparam logic [3:0] REG_CLOSE_TMO = 4'h8;

  // Clear register fields: bit 8 clears all, bits 2:0 pick one, bit 9 enables single clear
  localparam int unsigned CLR_ALL_BIT = 8;
  localparam int unsigned CLR_ONE_BIT = 9;

  // Control register fields
  localparam int unsigned CTL_MTRIP_BIT  = 0;
  localparam int unsigned CTL_MCLOSE_BIT = 1;
  localparam int unsigned CTL_FAIL_BIT   = 2;

  // Status register fields
  localparam int unsigned ST_TRIP_BIT   = 0;
  localparam int unsigned ST_CLOSE_BIT  = 1;
  localparam int unsigned ST_HEALTH_BIT = 2;
  localparam int unsigned ST_BRK_LSB    = 3;

  // Interrupt event bits
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned EV_LATCH_BIT   = 0;
  localparam int unsigned EV_TRIP_BIT    = 1;
  localparam int unsigned EV_CLOSEFAIL   = 2;
  localparam int unsigned EV_UNKNOWN_BIT = 3;

  // Front-panel clear window and close-fail timer defaults
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLEAR_WINDOW_S  = 5;
  localparam int unsigned CLEAR_WINDOW_CY = CLEAR_WINDOW_S * CLK_HZ;
  localparam int unsigned CNT_W           = 32;
  localparam logic [31:0] CLOSE_TMO_RST   = 32'h000f_4240;

  // Breaker position decode
  typedef enum logic [1:0] {
    RLOS_BRK_UNKNOWN,
    RLOS_BRK_OPEN,
    RLOS_BRK_CLOSED
  } rlos_brk_t;
endpackage : rlos_pkg
`default_nettype wire

/* rtl/rlos_sync.sv */
// Three-stage input synchroniser with agreement of the last two stages
`default_nettype none
module rlos_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);
  logic [W-1:0] s1Q;
  logic [W-1:0] s2Q;
  logic [W-1:0] s3Q;
  wire  [W-1:0] agree = ~(s2Q ^ s3Q);

  // First stage feeds only the second; output moves only when stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1Q     <= '0;
      s2Q     <= '0;
      s3Q     <= '0;
      syncOut <= '0;
    end else begin
      s1Q     <= asyncIn;
      s2Q     <= s1Q;
      s3Q     <= s2Q;
      syncOut <= (agree & s3Q) | (~agree & syncOut);
    end
  end
endmodule : rlos_sync
`default_nettype wire

/* rtl/rlos_panel.sv */
// Front-panel clear button: press opens a confirm window, confirm clears seal-ins
`default_nettype none
module rlos_panel (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Synchronised panel buttons
  input  wire logic clearBtn,
  input  wire logic confirmBtn,
  // Prompt and clear request
  output var  logic promptOut,
  output var  logic clearAllPulse
);
  typedef enum logic [1:0] {RLOS_P_IDLE, RLOS_P_PROMPT} rlos_pstate_t;
  rlos_pstate_t stateQ;
  logic [31:0]  winQ;
  logic         clearBtnQ;
  logic         confirmQ;
  wire          clearEdge   = clearBtn & ~clearBtnQ;
  wire          confirmEdge = confirmBtn & ~confirmQ;
  wire          winDone     = (winQ == 32'h0000_0000);

  // Prompt stays up for the window; confirmation inside it clears, else it lapses
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateQ        <= RLOS_P_IDLE;
      winQ          <= 32'h0000_0000;
      clearBtnQ     <= 1'b0;
      confirmQ      <= 1'b0;
      clearAllPulse <= 1'b0;
    end else begin
      clearBtnQ     <= clearBtn;
      confirmQ      <= confirmBtn;
      clearAllPulse <= 1'b0;
      case (stateQ)
        RLOS_P_IDLE: begin
          if (clearEdge) begin
            stateQ <= RLOS_P_PROMPT;
            winQ   <= 32'(rlos_pkg::CLEAR_WINDOW_CY - 1);
          end
        end
        RLOS_P_PROMPT: begin
          if (confirmEdge) begin
            clearAllPulse <= 1'b1;
            stateQ        <= RLOS_P_IDLE;
          end else if (winDone) begin
            stateQ <= RLOS_P_IDLE;
          end else begin
            winQ <= winQ - 32'h0000_0001;
          end
        end
        default: stateQ <= RLOS_P_IDLE;
      endcase
    end
  end

  assign promptOut = (stateQ == RLOS_P_PROMPT);
endmodule : rlos_panel
`default_nettype wire

/* rtl/rlos_core.sv */
// Relay logical outputs: real-time and sealed-in alarms, trip, close, health
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none
module rlos_core (
  // Clock and reset
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst,
  // Register port
  input  wire logic [rlos_pkg::ADDR_W-1:0]           regAddr,
  input  wire logic [rlos_pkg::DATA_W-1:0]           regWdata,
  input  wire logic                                  regWrite,
  input  wire logic                                  regRead,
  output var  logic [rlos_pkg::DATA_W-1:0]           regRdata,
  // Protective element conditions (same clock)
  input  wire logic [rlos_pkg::ALARM_COUNT-1:0]      alarmCond,
  input  wire logic [rlos_pkg::ALARM_COUNT-1:0]      ocEnable,
  input  wire logic                                  recloseCmd,
  input  wire logic                                  selfTestFail,
  // Remote protocol clear
  input  wire logic                                  remoteClrOne,
  input  wire logic                                  remoteClrAll,
  input  wire logic [rlos_pkg::IDX_W-1:0]            remoteClrIdx,
  // Pins from outside
  input  wire logic                                  breaker_closed_aux_input,
  input  wire logic                                  breaker_open_aux_input,
  input  wire logic                                  openInput,
  input  wire logic                                  closeInput,
  input  wire logic                                  panelClearBtn,
  input  wire logic                                  panelConfirmBtn,
  input  wire logic                                  panelTripBtn,
  input  wire logic                                  panelCloseBtn,
  // Logical outputs
  output var  logic [rlos_pkg::ALARM_COUNT-1:0]      realtimeOut,
  output var  logic [rlos_pkg::ALARM_COUNT-1:0]      latchedOut,
  output var  logic                                  tripOut,
  output var  logic                                  closeOut,
  output var  logic                                  healthOut,
  output var  logic                                  selfCheckContact,
  output var  logic                                  failLamp,
  output var  logic                                  panelPrompt,
  output var  logic [1:0]                            breakerState,
  output var  logic                                  irqOut
);
  localparam int unsigned N = rlos_pkg::ALARM_COUNT;

  // Pin synchronisation
  logic [5:0] pinSync;
  rlos_sync #(.W(6)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({breaker_closed_aux_input, breaker_open_aux_input, openInput,
               closeInput, panelTripBtn, panelCloseBtn}),
    .syncOut (pinSync)
  );
  wire auxClosed = pinSync[5];
  wire auxOpen   = pinSync[4];
  wire openSync  = pinSync[3];
  wire closeSync = pinSync[2];
  wire mTripPin  = pinSync[1];
  wire mClosePin = pinSync[0];

  logic [1:0] btnSync;
  rlos_sync #(.W(2)) u_btn (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({panelClearBtn, panelConfirmBtn}),
    .syncOut (btnSync)
  );

  // Front-panel clear sequence
  logic panelClrAll;
  rlos_panel u_panel (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .clearBtn      (btnSync[1]),
    .confirmBtn    (btnSync[0]),
    .promptOut     (panelPrompt),
    .clearAllPulse (panelClrAll)
  );

  // Register decode
  wire wrClear   = regWrite & (regAddr == rlos_pkg::REG_CLEAR);
  wire wrControl = regWrite & (regAddr == rlos_pkg::REG_CONTROL);
  wire wrIrqClr  = regWrite & (regAddr == rlos_pkg::REG_IRQ_CLR);
  wire wrIrqEn   = regWrite & (regAddr == rlos_pkg::REG_IRQ_EN);
  wire wrTmo     = regWrite & (regAddr == rlos_pkg::REG_CLOSE_TMO);
  wire toolClrAll = wrClear & regWdata[rlos_pkg::CLR_ALL_BIT];
  wire toolClrOne = wrClear & regWdata[rlos_pkg::CLR_ONE_BIT];
  wire [rlos_pkg::IDX_W-1:0] toolIdx = regWdata[rlos_pkg::IDX_W-1:0];
  wire clrAll = toolClrAll | remoteClrAll | panelClrAll;

  logic [2:0]  controlQ;
  logic [31:0] closeTmoQ;
  logic [rlos_pkg::IRQ_W-1:0] irqStatQ;
  logic [rlos_pkg::IRQ_W-1:0] irqEnQ;

  // Sealed-in alarms, one per condition; set wins over any clear
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_seal
      wire clrThis = clrAll | (toolClrOne & (toolIdx == rlos_pkg::IDX_W'(gi)))
                   | (remoteClrOne & (remoteClrIdx == rlos_pkg::IDX_W'(gi)));
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          latchedOut[gi] <= 1'b0;
        end else if (alarmCond[gi]) begin
          latchedOut[gi] <= 1'b1;
        end else if (clrThis) begin
          latchedOut[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Real-time copy registered straight from the condition, separate port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      realtimeOut <= '0;
    end else begin
      realtimeOut <= alarmCond;
    end
  end

  // Breaker position decode
  wire [1:0] brkNext = (auxClosed & ~auxOpen) ? 2'(rlos_pkg::RLOS_BRK_CLOSED)
                     : (~auxClosed & auxOpen) ? 2'(rlos_pkg::RLOS_BRK_OPEN)
                     : 2'(rlos_pkg::RLOS_BRK_UNKNOWN);
  wire brkClosed = (brkNext == 2'(rlos_pkg::RLOS_BRK_CLOSED));

  // Trip and close requests; manual requests come from pins or control register
  wire ocTrip   = |(alarmCond & ocEnable);
  wire tripReq  = ocTrip | openSync | mTripPin | controlQ[rlos_pkg::CTL_MTRIP_BIT];
  wire closeReq = recloseCmd | closeSync | mClosePin | controlQ[rlos_pkg::CTL_MCLOSE_BIT];

  logic [31:0] closeCntQ;
  wire closeTimeout = closeOut & (closeCntQ == 32'h0000_0000);
  wire closeEnd     = closeOut & (brkClosed | closeTimeout);

  // Trip drives the physical contact and this output from one flop, so they agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tripOut <= 1'b0;
    end else begin
      tripOut <= tripReq;
    end
  end

  // Close holds until the breaker reads closed or the close-fail timer runs out
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      closeOut  <= 1'b0;
      closeCntQ <= 32'h0000_0000;
    end else if (closeEnd) begin
      closeOut <= 1'b0;
    end else if (closeOut) begin
      closeCntQ <= closeCntQ - 32'h0000_0001;
    end else if (closeReq) begin
      closeOut  <= 1'b1;
      closeCntQ <= closeTmoQ;
    end
  end

  // Health, contact and lamp come from one flop; a software fail bit forces failure
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      healthOut <= 1'b1;
    end else begin
      healthOut <= ~(selfTestFail | controlQ[rlos_pkg::CTL_FAIL_BIT]);
    end
  end
  assign selfCheckContact = healthOut;
  assign failLamp         = ~healthOut;

  // Control, timeout and breaker state registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      controlQ     <= 3'h0;
      closeTmoQ    <= rlos_pkg::CLOSE_TMO_RST;
      breakerState <= 2'(rlos_pkg::RLOS_BRK_UNKNOWN);
    end else begin
      breakerState <= brkNext;
      if (wrControl) controlQ <= regWdata[2:0];
      if (wrTmo) closeTmoQ <= regWdata;
    end
  end

  // Sticky interrupt events; a new event beats a clear in the same cycle
  wire [rlos_pkg::IRQ_W-1:0] irqEv = {brkNext == 2'(rlos_pkg::RLOS_BRK_UNKNOWN), closeTimeout,
                                     tripReq & ~tripOut, |(alarmCond & ~latchedOut)};
  wire [rlos_pkg::IRQ_W-1:0] irqClr = wrIrqClr ? regWdata[rlos_pkg::IRQ_W-1:0] : 4'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStatQ <= 4'h0;
      irqEnQ   <= 4'h0;
    end else begin
      irqStatQ <= irqEv | (irqStatQ & ~irqClr);
      if (wrIrqEn) irqEnQ <= regWdata[rlos_pkg::IRQ_W-1:0];
    end
  end
  assign irqOut = |(irqStatQ & irqEnQ);

  // Read mux; unmapped and write-only offsets read zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (regAddr)
      rlos_pkg::REG_REALTIME:  rdMux = {24'h00_0000, realtimeOut};
      rlos_pkg::REG_LATCHED:   rdMux = {24'h00_0000, latchedOut};
      rlos_pkg::REG_CONTROL:   rdMux = {29'h0000_0000, controlQ};
      rlos_pkg::REG_STATUS:    rdMux = {27'h000_0000, breakerState, healthOut, closeOut, tripOut};
      rlos_pkg::REG_IRQ_STAT:  rdMux = {28'h000_0000, irqStatQ};
      rlos_pkg::REG_IRQ_EN:    rdMux = {28'h000_0000, irqEnQ};
      rlos_pkg::REG_CLOSE_TMO: rdMux = closeTmoQ;
      default:                 rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRead ? rdMux : 32'h0000_0000;
    end
  end

  // Checks
  property p_seal_hold;
    @(posedge sys_clk) disable iff (rst) alarmCond[0] |=> latchedOut[0];
  endproperty
  a_seal_hold: assert property (p_seal_hold) else $error("latch did not set");
  property p_set_wins;
    @(posedge sys_clk) disable iff (rst) (alarmCond[1] && clrAll) |=> latchedOut[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");
  property p_realtime;
    @(posedge sys_clk) disable iff (rst) !alarmCond[2] |=> !realtimeOut[2];
  endproperty
  a_realtime: assert property (p_realtime) else $error("realtime stuck");
  property p_clr_all;
    @(posedge sys_clk) disable iff (rst) (clrAll && alarmCond == '0) |=> latchedOut == '0;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("clear all failed");
  property p_trip;
    @(posedge sys_clk) disable iff (rst) openSync |=> tripOut;
  endproperty
  a_trip: assert property (p_trip) else $error("trip missing");
  property p_close_end;
    @(posedge sys_clk) disable iff (rst) (closeOut && brkClosed) |=> !closeOut;
  endproperty
  a_close_end: assert property (p_close_end) else $error("close not released");
  property p_health;
    @(posedge sys_clk) disable iff (rst) selfTestFail |=> !healthOut && failLamp;
  endproperty
  a_health: assert property (p_health) else $error("health did not drop");
  property p_unknown;
    @(posedge sys_clk) disable iff (rst) (auxClosed == auxOpen) |=> breakerState == 2'(rlos_pkg::RLOS_BRK_UNKNOWN);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown not shown");
  c_panel_clear: cover property (@(posedge sys_clk) disable iff (rst) panelClrAll);
  c_close_tmo:   cover property (@(posedge sys_clk) disable iff (rst) closeTimeout);
  c_seal_after:  cover property (@(posedge sys_clk) disable iff (rst) !alarmCond[0] && latchedOut[0]);
endmodule : rlos_core
`default_nettype wire

/* verification/rlos_breaker_model.sv */
// Behavioural breaker whose auxiliary contacts follow the close and trip coils
`default_nettype none
module rlos_breaker_model #(
  parameter int unsigned TRAVEL = 5
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Coils from the relay
  input  wire logic closeCoil,
  input  wire logic tripCoil,
  // Fault injection from the bench
  input  wire logic stuckOpen,
  input  wire logic forceUnknown,
  // Auxiliary contacts
  output var  logic closedAux,
  output var  logic openAux
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        posQ;
  int unsigned travelQ;
  // Contacts move only once the coil has stayed energised for the travel time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      posQ    <= 1'b0;
      travelQ <= 0;
    end else if ((closeCoil && !posQ && !stuckOpen) || (tripCoil && posQ)) begin
      if (travelQ == TRAVEL - 1) begin
        posQ    <= ~posQ;
        travelQ <= 0;
      end else begin
        travelQ <= travelQ + 1;
      end
    end else begin
      travelQ <= 0;
    end
  end
  // A broken wiring loop leaves both contacts reading 0, as unassigned inputs do
  assign closedAux = forceUnknown ? 1'b0 : posQ;
  assign openAux   = forceUnknown ? 1'b0 : ~posQ;
endmodule : rlos_breaker_model
`default_nettype wire

/* verification/rlos_core_tb_top.sv */
// Self-checking bench for the relay logical output seal-in block
`default_nettype none
module rlos_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and register port
  logic        sys_clk, rst, regWrite, regRead;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, rv;
  // Conditions, commands and outputs
  logic [7:0]  alarmCond, ocEnable, realtimeOut, latchedOut;
  logic        recloseCmd, selfTestFail, remoteClrOne, remoteClrAll;
  logic [2:0]  remoteClrIdx;
  logic [5:0]  pinV; // open, close, clear, confirm, trip, close button
  logic        closedAux, openAux, stuckOpen, forceUnknown;
  logic        tripOut, closeOut, healthOut, selfCheckContact, failLamp, panelPrompt, irqOut;
  logic [1:0]  breakerState;
  int          errCount, nChecks, n;

  rlos_core u_rlos_core (.sys_clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .alarmCond, .ocEnable, .recloseCmd, .selfTestFail, .remoteClrOne, .remoteClrAll, .remoteClrIdx,
    .breaker_closed_aux_input(closedAux), .breaker_open_aux_input(openAux), .openInput(pinV[0]),
    .closeInput(pinV[1]), .panelClearBtn(pinV[2]), .panelConfirmBtn(pinV[3]), .panelTripBtn(pinV[4]),
    .panelCloseBtn(pinV[5]), .realtimeOut, .latchedOut, .tripOut, .closeOut, .healthOut,
    .selfCheckContact, .failLamp, .panelPrompt, .breakerState, .irqOut);

  rlos_breaker_model u_rlos_breaker_model (.sys_clk, .rst, .closeCoil(closeOut), .tripCoil(tripOut),
    .stuckOpen, .forceUnknown, .closedAux, .openAux);

  // Free-running 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  // Bus cycles: one strobe cycle each, read data sampled in the following cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // Async pins are held three cycles so the synchroniser stages agree
  task automatic pin(input int k);
    cyc(1);
    pinV[k] <= 1'b1;
    cyc(3);
    pinV[k] <= 1'b0;
  endtask : pin

  task automatic t_reset;
    cyc(6);
    #1;
    chk(realtimeOut | latchedOut, 32'h0);
    chk({tripOut, closeOut, panelPrompt, irqOut}, 32'h0);
    chk({healthOut, selfCheckContact, failLamp}, 32'h6);
    chk(breakerState, 32'h1);
    rd(rlos_pkg::REG_CLOSE_TMO, rv);
    chk(rv, rlos_pkg::CLOSE_TMO_RST);
    rd(4'hf, rv);
    chk(rv, 32'h0);
    rd(rlos_pkg::REG_STATUS, rv);
    chk(rv, 32'h0c);
    // Aux inputs read equal until the synchroniser fills, so the unknown event is already sticky
    rd(rlos_pkg::REG_IRQ_STAT, rv);
    chk(rv, 32'h8);
    wr(rlos_pkg::REG_IRQ_CLR, 32'hf);
    rd(rlos_pkg::REG_IRQ_STAT, rv);
    chk(rv, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_seal;
    cyc(1);
    alarmCond <= 8'h0a;
    cyc(2);
    #1 chk(realtimeOut, 32'h0a);
    chk(latchedOut, 32'h0a);
    cyc(1);
    alarmCond <= 8'h02;
    cyc(2);
    #1 chk(realtimeOut, 32'h02);
    chk(latchedOut, 32'h0a);
    // Remote single clear, then remote clear-all while bit 1 is still present
    cyc(1);
    remoteClrIdx <= 3'h3;
    remoteClrOne <= 1'b1;
    cyc(1);
    remoteClrOne <= 1'b0;
    cyc(2);
    #1 chk(latchedOut, 32'h02);
    cyc(1);
    remoteClrAll <= 1'b1;
    cyc(1);
    remoteClrAll <= 1'b0;
    alarmCond    <= 8'h30;
    cyc(1);
    alarmCond <= 8'h00;
    cyc(2);
    #1 chk(latchedOut, 32'h32);
    rd(rlos_pkg::REG_LATCHED, rv);
    chk(rv, 32'h32);
    rd(rlos_pkg::REG_REALTIME, rv);
    chk(rv, 32'h0);
    wr(rlos_pkg::REG_CLEAR, 32'h0000_0204);
    cyc(2);
    #1 chk(latchedOut, 32'h22);
    cyc(1);
    remoteClrAll <= 1'b1;
    cyc(1);
    remoteClrAll <= 1'b0;
    alarmCond    <= 8'h81;
    cyc(1);
    alarmCond <= 8'h00;
    cyc(2);
    #1 chk(latchedOut, 32'h81);
    wr(rlos_pkg::REG_CLEAR, 32'h0000_0100);
    cyc(2);
    #1 chk(latchedOut, 32'h0);
    // Panel press alone only prompts; confirm clears
    cyc(1);
    alarmCond <= 8'h01;
    cyc(1);
    alarmCond <= 8'h00;
    pin(2);
    cyc(4);
    #1 chk({panelPrompt, latchedOut}, 32'h101);
    pin(3);
    cyc(6);
    #1 chk(latchedOut, 32'h0);
    $display("test seal-in done");
  endtask : t_seal

  task automatic t_trip;
    cyc(1);
    ocEnable  <= 8'h04;
    alarmCond <= 8'h02;
    cyc(3);
    #1 chk(tripOut, 32'h0);
    cyc(1);
    alarmCond <= 8'h04;
    cyc(3);
    #1 chk(tripOut, 32'h1);
    cyc(1);
    alarmCond <= 8'h00;
    // Open input, panel trip, then manual trip through the control register
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      if (k == 2) wr(rlos_pkg::REG_CONTROL, 32'h1);
      else pinV[k * 4] <= 1'b1;
      cyc(6);
      #1 chk(tripOut, 32'h1);
      wr(rlos_pkg::REG_CONTROL, 32'h0);
      pinV <= 6'h00;
      cyc(6);
      #1 chk(tripOut, 32'h0);
    end
    // Sticky status, enable mask and write-one clear
    wr(rlos_pkg::REG_IRQ_EN, 32'h2);
    cyc(1);
    #1 chk(irqOut, 32'h1);
    rd(rlos_pkg::REG_IRQ_STAT, rv);
    chk(rv, 32'h3);
    wr(rlos_pkg::REG_IRQ_EN, 32'h0);
    cyc(1);
    #1 chk(irqOut, 32'h0);
    wr(rlos_pkg::REG_IRQ_CLR, 32'h3);
    rd(rlos_pkg::REG_IRQ_STAT, rv);
    chk(rv, 32'h0);
    $display("test trip done");
  endtask : t_trip

  task automatic t_close_fail;
    wr(rlos_pkg::REG_CLOSE_TMO, 32'h14);
    rd(rlos_pkg::REG_CLOSE_TMO, rv);
    chk(rv, 32'h14);
    cyc(1);
    stuckOpen  <= 1'b1;
    recloseCmd <= 1'b1;
    cyc(1);
    recloseCmd <= 1'b0;
    n = 0;
    // Sample from the cycle right after the request edge, so every one of the value+1 cycles counts
    for (int i = 0; i < 100; i++) begin
      #1 if (closeOut === 1'b1) n++;
      cyc(1);
    end
    #1 chk(n, 32'd21);
    chk(breakerState, 32'h1);
    rd(rlos_pkg::REG_IRQ_STAT, rv);
    chk(rv & 32'h4, 32'h4);
    stuckOpen <= 1'b0;
    $display("test close fail done");
  endtask : t_close_fail

  // Close input, panel close and manual close each end on the breaker closing
  task automatic t_close;
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        wr(rlos_pkg::REG_CONTROL, 32'h2);
        wr(rlos_pkg::REG_CONTROL, 32'h0);
      end else begin
        pin(1 + k * 4);
      end
      n = 0;
      for (int i = 0; i < 40; i++) begin
        cyc(1);
        #1 if (closeOut === 1'b1) n++;
      end
      chk(breakerState, 32'h2);
      chk(closeOut, 32'h0);
      chk(32'(n > 0 && n < 20), 32'h1);
      wr(rlos_pkg::REG_CONTROL, 32'h1);
      cyc(10);
      wr(rlos_pkg::REG_CONTROL, 32'h0);
      cyc(8);
      #1 chk(breakerState, 32'h1);
    end
    $display("test close done");
  endtask : t_close

  task automatic t_unknown;
    cyc(1);
    forceUnknown <= 1'b1;
    wr(rlos_pkg::REG_IRQ_EN, 32'h8);
    cyc(6);
    #1 chk(breakerState, 32'h0);
    chk(irqOut, 32'h1);
    cyc(1);
    forceUnknown <= 1'b0;
    cyc(6);
    wr(rlos_pkg::REG_IRQ_CLR, 32'h8);
    cyc(1);
    #1 chk(irqOut, 32'h0);
    chk(breakerState, 32'h1);
    $display("test unknown done");
  endtask : t_unknown

  task automatic t_health;
    cyc(1);
    selfTestFail <= 1'b1;
    cyc(4);
    #1 chk({healthOut, selfCheckContact, failLamp}, 32'h1);
    rd(rlos_pkg::REG_STATUS, rv);
    chk(rv, 32'h08);
    rd(rlos_pkg::REG_IRQ_EN, rv);
    chk(rv, 32'h8);
    $display("test health done");
  endtask : t_health

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // Main sequence: all inputs start idle, reset held for 16 cycles
  initial begin
    {rst, regWrite, regRead, regAddr, regWdata} = {1'b1, 38'h0};
    {alarmCond, ocEnable, recloseCmd, selfTestFail, remoteClrOne, remoteClrAll, remoteClrIdx} = '0;
    {pinV, stuckOpen, forceUnknown} = '0;
    cyc(16);
    rst <= 1'b0;
    t_reset();
    t_seal();
    t_trip();
    t_close_fail();
    t_close();
    t_unknown();
    t_health();
    wrap_up();
  end

  // Watchdog well beyond the roughly 500 cycles the tests need
  initial begin
    #(100 * 20000);
    errCount++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : rlos_core_tb_top
`default_nettype wire
